/* File: rtl/scc_regs.svh */
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_CLK_MHZ 125
`define SCC_SETTLE_NS 1000
`define SCC_SETTLE_CYC ((`SCC_SETTLE_NS * `SCC_CLK_MHZ + 999) / 1000)
`define SCC_LOCK_REF 200
`define SCC_RATE_FULL 2'h0
`define SCC_RATE_HALF 2'h1
`define SCC_RATE_QUARTER 2'h2
`define SCC_ALIGN_COMMA 2'h1
`define SCC_COMMA_POS 7'h1F
`define SCC_COMMA_NEG 7'h60
`define SCC_COMMA_LEN 7
`define SCC_SYM_W 10
`define SCC_EQ_NONE 4'h0
`define SCC_EQ_FULL 4'h1
`define SCC_EQ_PART_BIT 3
`define SCC_EQ_INTERVAL 1024
`define SCC_EQ_GAIN_RST 4'hF
`define SCC_EQ_ZERO_RST 3'h4
`define SCC_WIN_LEN 8
`endif

/* File: rtl/scc_pkg.sv */
package scc_pkg;
  typedef enum logic [1:0] {PLL_OFF, PLL_SETTLE, PLL_LOCK_WAIT, PLL_LOCKED} scc_pll_state_type;
  typedef enum logic [1:0] {EQ_FLAT, EQ_ADAPT_FULL, EQ_ADAPT_GAIN} scc_eq_mode_type;
endpackage

/* File: rtl/scc_stream_if.sv */
`timescale 1ns/1ps
interface scc_stream_if #(parameter int W = 10);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* File: rtl/scc_fifo.sv */
`timescale 1ns/1ps
module scc_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill and drain sides
  scc_stream_if.snk wr,
  scc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic room_r;
  logic push;
  logic pop;
  logic [AW:0] cnt_nxt;

  assign push = wr.valid && room_r;
  assign pop = rd.valid && rd.ready;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign wr.ready = room_r;
  assign rd.valid = cnt_r != '0;
  assign rd.data = mem[rp_r];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_r] <= wr.data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      room_r <= 1'b1;
    end
    else
    begin
      wp_r <= push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
      rp_r <= pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
      cnt_r <= cnt_nxt;
      room_r <= cnt_nxt != (AW+1)'(DEPTH);
    end
  end
endmodule

/* File: rtl/scc_top.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top #(
  parameter int SYM_W = `SCC_SYM_W,
  parameter int FIFO_DEPTH = 8,
  parameter int LOCK_REF = `SCC_LOCK_REF,
  parameter int EQ_INTERVAL = `SCC_EQ_INTERVAL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // PLL control
  input wire logic pll_power_on,
  input wire logic [3:0] pll_multiplier,
  input wire logic serdes_reference_clock,
  output logic pll_locked,
  output logic [5:0] pll_mult_x2,
  output logic pll_mult_bad,
  // Rate selection
  input wire logic [1:0] tx_rate,
  input wire logic [1:0] rx_rate,
  output logic [2:0] tx_rate_scale_factor_x2,
  output logic [2:0] rx_rate_scale_factor_x2,
  // Transmit side
  input wire logic transmitter_on,
  input wire logic [SYM_W-1:0] tx_sym_data,
  input wire logic tx_sym_valid,
  output logic tx_sym_ready,
  output logic tx_serial,
  output logic serializer_byte_clock,
  // Receive side and clock recovery
  input wire logic receiver_on,
  input wire logic rx_serial,
  input wire logic rx_phase,
  input wire logic signal_loss_monitor,
  input wire logic signal_loss_detect,
  input wire logic clock_recovery_mode,
  output logic [6:0] cdr_phase,
  output logic signed [5:0] cdr_freq,
  output logic cdr_frozen,
  // Symbol alignment
  input wire logic [1:0] align_mode,
  input wire logic align_jog,
  output logic [SYM_W-1:0] rx_sym_data,
  output logic rx_sym_valid,
  output logic rx_comma_seen,
  // Equalizer
  input wire logic [3:0] adaptive_gain_setting,
  input wire logic eq_boost_vote,
  input wire logic eq_cut_vote,
  output logic [3:0] eq_gain,
  output logic [2:0] eq_zero
);
  localparam int SETTLE_CYC = `SCC_SETTLE_CYC;
  localparam int EQ_CW = $clog2(EQ_INTERVAL);
  localparam int SCW = $clog2(SYM_W + 1);

  // PLL power-up sequencing
  scc_pkg::scc_pll_state_type pll_st_r, pll_st_nxt;
  logic [8:0] pll_cnt_r, pll_cnt_nxt;
  logic ref_d_r;
  logic ref_rise;
  logic [5:0] mult_x2;
  logic mult_bad;

  assign ref_rise = serdes_reference_clock && !ref_d_r;

  always_comb
  begin
    mult_bad = 1'b0;
    unique case (pll_multiplier)
      4'h0: mult_x2 = 6'h08;
      4'h1: mult_x2 = 6'h0A;
      4'h2: mult_x2 = 6'h0C;
      4'h3: mult_x2 = 6'h10;
      4'h4: mult_x2 = 6'h14;
      4'h5: mult_x2 = 6'h18;
      4'h6: mult_x2 = 6'h19;
      4'h7: mult_x2 = 6'h1E;
      4'h8: mult_x2 = 6'h28;
      4'h9: mult_x2 = 6'h32;
      default:
      begin
        mult_x2 = 6'h00;
        mult_bad = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    pll_st_nxt = pll_st_r;
    pll_cnt_nxt = pll_cnt_r;
    unique case (pll_st_r)
      scc_pkg::PLL_OFF:
      begin
        pll_cnt_nxt = '0;
        if (pll_power_on && !mult_bad)
        begin
          pll_st_nxt = scc_pkg::PLL_SETTLE;
        end
      end
      scc_pkg::PLL_SETTLE:
      begin
        pll_cnt_nxt = pll_cnt_r + 9'h001;
        if (pll_cnt_r == 9'(SETTLE_CYC - 1))
        begin
          pll_st_nxt = scc_pkg::PLL_LOCK_WAIT;
          pll_cnt_nxt = '0;
        end
      end
      scc_pkg::PLL_LOCK_WAIT:
      begin
        if (ref_rise)
        begin
          pll_cnt_nxt = pll_cnt_r + 9'h001;
          if (pll_cnt_r == 9'(LOCK_REF - 1))
          begin
            pll_st_nxt = scc_pkg::PLL_LOCKED;
          end
        end
      end
      scc_pkg::PLL_LOCKED: pll_cnt_nxt = '0;
    endcase
    if (!pll_power_on)
    begin
      pll_st_nxt = scc_pkg::PLL_OFF;
      pll_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pll_st_r <= scc_pkg::PLL_OFF;
      pll_cnt_r <= '0;
      ref_d_r <= 1'b0;
      pll_locked <= 1'b0;
      pll_mult_x2 <= '0;
      pll_mult_bad <= 1'b0;
    end
    else
    begin
      pll_st_r <= pll_st_nxt;
      pll_cnt_r <= pll_cnt_nxt;
      ref_d_r <= serdes_reference_clock;
      pll_locked <= pll_st_nxt == scc_pkg::PLL_LOCKED;
      pll_mult_x2 <= mult_x2;
      pll_mult_bad <= mult_bad;
    end
  end

  // Per-direction sample enables, index 0 transmit, 1 receive
  logic [1:0] rate_en;
  logic [1:0] rate_code [2];
  logic [2:0] scale_x2 [2];
  assign rate_code[0] = tx_rate;
  assign rate_code[1] = rx_rate;

  for (genvar d = 0; d < 2; d++)
  begin : g_rate
    logic [1:0] div_r;
    assign rate_en[d] = pll_locked && (
      (rate_code[d] == `SCC_RATE_FULL) ||
      (rate_code[d] == `SCC_RATE_HALF && div_r[0]) ||
      (rate_code[d] == `SCC_RATE_QUARTER && div_r == 2'h3));
    assign scale_x2[d] = (rate_code[d] == `SCC_RATE_FULL) ? 3'h1 :
                         (rate_code[d] == `SCC_RATE_HALF) ? 3'h2 :
                         (rate_code[d] == `SCC_RATE_QUARTER) ? 3'h4 : 3'h0;
    always_ff @(posedge clk)
    begin
      if (!nrst || !pll_locked)
      begin
        div_r <= '0;
      end
      else
      begin
        div_r <= div_r + 2'h1;
      end
    end
  end

  // Transmit path: FIFO then serializer
  scc_stream_if #(.W(SYM_W)) tx_in ();
  scc_stream_if #(.W(SYM_W)) tx_out ();
  assign tx_in.data = tx_sym_data;
  assign tx_in.valid = tx_sym_valid;
  assign tx_sym_ready = tx_in.ready;

  scc_fifo #(.W(SYM_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .nrst(nrst),
    .wr(tx_in),
    .rd(tx_out)
  );

  logic [SYM_W-1:0] ser_r;
  logic [SCW-1:0] ser_left_r;
  logic [SCW-1:0] bclk_cnt_r;
  logic tx_step;
  logic tx_load;
  logic bclk_flip;

  assign tx_step = rate_en[0] && transmitter_on;
  assign tx_load = tx_step && ser_left_r == '0 && tx_out.valid;
  assign tx_out.ready = tx_load;
  assign bclk_flip = rate_en[0] && bclk_cnt_r == SCW'(SYM_W / 2 - 1);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ser_r <= '0;
      ser_left_r <= '0;
      tx_serial <= 1'b0;
      bclk_cnt_r <= '0;
      serializer_byte_clock <= 1'b0;
      tx_rate_scale_factor_x2 <= '0;
      rx_rate_scale_factor_x2 <= '0;
    end
    else
    begin
      tx_rate_scale_factor_x2 <= scale_x2[0];
      rx_rate_scale_factor_x2 <= scale_x2[1];
      if (rate_en[0])
      begin
        bclk_cnt_r <= bclk_flip ? '0 : bclk_cnt_r + SCW'(1);
        serializer_byte_clock <= serializer_byte_clock ^ bclk_flip;
      end
      if (!transmitter_on)
      begin
        tx_serial <= 1'b0;
      end
      else if (tx_load)
      begin
        tx_serial <= tx_out.data[SYM_W-1];
        ser_r <= tx_out.data << 1;
        ser_left_r <= SCW'(SYM_W - 1);
      end
      else if (tx_step && ser_left_r != '0)
      begin
        tx_serial <= ser_r[SYM_W-1];
        ser_r <= ser_r << 1;
        ser_left_r <= ser_left_r - SCW'(1);
      end
    end
  end

  // Clock recovery voting
  logic rx_step;
  logic prev_bit_r;
  logic [2:0] win_r;
  logic [3:0] early_r;
  logic [3:0] late_r;
  logic trans;
  logic vote_e;
  logic vote_l;
  logic [3:0] early_t;
  logic [3:0] late_t;
  logic win_end;
  logic maj_e;
  logic maj_l;
  logic frozen;
  logic signed [5:0] freq_nxt;
  logic [6:0] step1;

  assign rx_step = rate_en[1] && receiver_on;
  assign frozen = signal_loss_monitor && signal_loss_detect;
  assign trans = rx_serial != prev_bit_r;
  assign vote_e = trans && rx_phase == rx_serial;
  assign vote_l = trans && rx_phase != rx_serial;
  assign early_t = early_r + 4'(vote_e);
  assign late_t = late_r + 4'(vote_l);
  assign win_end = win_r == 3'(`SCC_WIN_LEN - 1);
  assign maj_e = win_end && early_t > late_t;
  assign maj_l = win_end && late_t > early_t;
  assign step1 = maj_e ? 7'h7F : maj_l ? 7'h01 : 7'h00;
  assign freq_nxt = (maj_l && cdr_freq != 6'sd31) ? cdr_freq + 6'sd1 :
                    (maj_e && cdr_freq != 6'sh20) ? cdr_freq - 6'sd1 : cdr_freq;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prev_bit_r <= 1'b0;
      win_r <= '0;
      early_r <= '0;
      late_r <= '0;
      cdr_phase <= '0;
      cdr_freq <= '0;
      cdr_frozen <= 1'b0;
    end
    else
    begin
      cdr_frozen <= frozen;
      if (rx_step && frozen)
      begin
        prev_bit_r <= rx_serial;
        win_r <= '0;
        early_r <= '0;
        late_r <= '0;
      end
      else if (rx_step)
      begin
        prev_bit_r <= rx_serial;
        win_r <= win_r + 3'h1;
        early_r <= win_end ? '0 : early_t;
        late_r <= win_end ? '0 : late_t;
        if (win_end && clock_recovery_mode)
        begin
          cdr_freq <= freq_nxt;
          cdr_phase <= cdr_phase + step1 + 7'(freq_nxt);
        end
        else if (win_end)
        begin
          cdr_phase <= cdr_phase + step1;
        end
      end
    end
  end

  // Deserializer with comma alignment and jog
  logic [SYM_W-1:0] des_r;
  logic [SCW-1:0] bits_r;
  logic [SYM_W-1:0] des_nxt;
  logic comma_hit;
  logic jog;
  logic [SCW-1:0] bits_nxt;

  assign des_nxt = {des_r[SYM_W-2:0], rx_serial};
  assign comma_hit = align_mode == `SCC_ALIGN_COMMA &&
    (des_nxt[6:0] == `SCC_COMMA_POS || des_nxt[6:0] == `SCC_COMMA_NEG);
  assign jog = align_jog && align_mode != `SCC_ALIGN_COMMA;
  assign bits_nxt = comma_hit ? SCW'(`SCC_COMMA_LEN) : jog ? bits_r : bits_r + SCW'(1);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      des_r <= '0;
      bits_r <= '0;
      rx_sym_data <= '0;
      rx_sym_valid <= 1'b0;
      rx_comma_seen <= 1'b0;
    end
    else
    begin
      rx_sym_valid <= 1'b0;
      if (rx_step)
      begin
        des_r <= des_nxt;
        rx_comma_seen <= rx_comma_seen || comma_hit;
        if (bits_nxt == SCW'(SYM_W))
        begin
          bits_r <= '0;
          rx_sym_data <= des_nxt;
          rx_sym_valid <= 1'b1;
        end
        else
        begin
          bits_r <= bits_nxt;
        end
      end
    end
  end

  // Adaptive equalizer
  scc_pkg::scc_eq_mode_type eq_mode;
  logic [EQ_CW-1:0] eq_cnt_r;
  logic signed [EQ_CW+1:0] eq_acc_r;
  logic signed [EQ_CW+1:0] eq_acc_t;
  logic eq_end;
  logic eq_up;
  logic eq_dn;

  assign eq_mode = (adaptive_gain_setting == `SCC_EQ_FULL) ? scc_pkg::EQ_ADAPT_FULL :
                   adaptive_gain_setting[`SCC_EQ_PART_BIT] ? scc_pkg::EQ_ADAPT_GAIN :
                   scc_pkg::EQ_FLAT;
  assign eq_acc_t = eq_acc_r + (EQ_CW+2)'(eq_boost_vote) - (EQ_CW+2)'(eq_cut_vote);
  assign eq_end = eq_cnt_r == EQ_CW'(EQ_INTERVAL - 1);
  assign eq_up = eq_end && eq_acc_t > 0;
  assign eq_dn = eq_end && eq_acc_t < 0;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      eq_cnt_r <= '0;
      eq_acc_r <= '0;
      eq_gain <= `SCC_EQ_GAIN_RST;
      eq_zero <= `SCC_EQ_ZERO_RST;
    end
    else if (eq_mode == scc_pkg::EQ_FLAT)
    begin
      eq_cnt_r <= '0;
      eq_acc_r <= '0;
      eq_gain <= `SCC_EQ_GAIN_RST;
    end
    else if (rx_step)
    begin
      eq_cnt_r <= eq_end ? '0 : eq_cnt_r + EQ_CW'(1);
      eq_acc_r <= eq_end ? '0 : eq_acc_t;
      if (eq_mode == scc_pkg::EQ_ADAPT_GAIN)
      begin
        eq_zero <= adaptive_gain_setting[2:0];
      end
      if (eq_up && eq_gain != 4'hF)
      begin
        eq_gain <= eq_gain + 4'h1;
      end
      else if (eq_up && eq_mode == scc_pkg::EQ_ADAPT_FULL && eq_zero != 3'h7)
      begin
        eq_zero <= eq_zero + 3'h1;
      end
      if (eq_dn && eq_gain != 4'h0)
      begin
        eq_gain <= eq_gain - 4'h1;
      end
      else if (eq_dn && eq_mode == scc_pkg::EQ_ADAPT_FULL && eq_zero != 3'h0)
      begin
        eq_zero <= eq_zero - 3'h1;
      end
    end
  end
endmodule

/* File: dv/scc_phy_model.sv */
`timescale 1ns/1ps
module scc_phy_model (
  // Clock
  input wire logic clk,
  // Pattern: 0 quiet, 1 alternating, 2 repeated symbol
  input wire logic [1:0] mode,
  input wire logic [9:0] sym,
  // Lane samples
  output logic rx_serial,
  output logic rx_phase
);
  logic [3:0] idx_r = 4'h9;
  logic nb;
  always @(negedge clk)
  begin
    nb = (mode == 2'h1) ? ~rx_serial : (mode == 2'h2) && sym[idx_r];
    idx_r <= (idx_r == 4'h0) ? 4'h9 : idx_r - 4'h1;
    rx_serial <= nb;
    // Phase sample equal to the new bit: the edge arrived early
    rx_phase <= nb;
  end
endmodule

/* File: dv/scc_checker_props.sv */
`timescale 1ns/1ps
module scc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // PLL
  input wire logic pll_power_on,
  input wire logic [3:0] pll_multiplier,
  input wire logic pll_locked,
  input wire logic [5:0] pll_mult_x2,
  input wire logic pll_mult_bad,
  // Transmit
  input wire logic [1:0] tx_rate,
  input wire logic [2:0] tx_rate_scale_factor_x2,
  input wire logic transmitter_on,
  input wire logic tx_serial,
  // Receive and equalizer
  input wire logic signal_loss_monitor,
  input wire logic signal_loss_detect,
  input wire logic [6:0] cdr_phase,
  input wire logic cdr_frozen,
  input wire logic [3:0] adaptive_gain_setting,
  input wire logic [3:0] eq_gain,
  input wire logic [2:0] eq_zero
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_lost;
    signal_loss_monitor && signal_loss_detect;
  endsequence
  a_reset_defaults: assert property ($rose(nrst) |-> !pll_locked && !tx_serial
    && !cdr_frozen && eq_gain == 4'hF && eq_zero == 3'h4)
    else $error("outputs not at reset values");
  a_settle_wait: assert property ($rose(pll_power_on) |=> !pll_locked [*8])
    else $error("lock before settling");
  a_lock_drop: assert property (!pll_power_on |=> !pll_locked)
    else $error("lock held without power");
  a_mult_bad: assert property (pll_multiplier > 4'h9 |=> pll_mult_bad && pll_mult_x2 == 6'h00)
    else $error("illegal multiplier accepted");
  a_tx_scale: assert property (tx_rate == 2'h2 |=> tx_rate_scale_factor_x2 == 3'h4)
    else $error("quarter rate scale wrong");
  a_tx_quiet: assert property (!transmitter_on [*2] |-> !tx_serial)
    else $error("serial output while transmitter off");
  a_freeze_hold: assert property (s_lost ##1 s_lost |=> cdr_frozen && $stable(cdr_phase))
    else $error("clock recovery moved while frozen");
  a_eq_flat: assert property ((adaptive_gain_setting == 4'h0) [*3] |-> eq_gain == 4'hF)
    else $error("flat mode gain not maximum");
endmodule
bind scc_top scc_checker scc_checker_inst (
  .clk, .nrst, .pll_power_on, .pll_multiplier, .pll_locked, .pll_mult_x2, .pll_mult_bad,
  .tx_rate, .tx_rate_scale_factor_x2, .transmitter_on, .tx_serial, .signal_loss_monitor,
  .signal_loss_detect, .cdr_phase, .cdr_frozen, .adaptive_gain_setting, .eq_gain, .eq_zero
);

/* File: dv/serdes_config_control_tb_top.sv */
`timescale 1ns/1ps
module serdes_config_control_tb_top;
  logic clk = 1'b0;
  logic serdes_reference_clock = 1'b0;
  logic nrst, pll_power_on, transmitter_on, tx_sym_valid;
  logic receiver_on, signal_loss_monitor, signal_loss_detect, clock_recovery_mode;
  logic align_jog, eq_boost_vote, eq_cut_vote, rx_serial, rx_phase;
  logic pll_locked, pll_mult_bad, tx_sym_ready, tx_serial, serializer_byte_clock;
  logic cdr_frozen, rx_sym_valid, rx_comma_seen;
  logic [1:0] tx_rate, rx_rate, align_mode, phy_mode;
  logic [2:0] tx_rate_scale_factor_x2, rx_rate_scale_factor_x2, eq_zero;
  logic [3:0] pll_multiplier, adaptive_gain_setting, eq_gain;
  logic [5:0] pll_mult_x2;
  logic [6:0] cdr_phase, p0;
  logic signed [5:0] cdr_freq;
  logic [9:0] tx_sym_data, rx_sym_data;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  logic [5:0] mult_x2 [11] = '{6'h08, 6'h0A, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h19, 6'h1E,
    6'h28, 6'h32, 6'h00};
  logic [2:0] scale_x2 [4] = '{3'h1, 3'h2, 3'h4, 3'h0};

  always #4 clk = ~clk;
  always @(negedge clk) serdes_reference_clock <= ~serdes_reference_clock;

  scc_phy_model scc_phy_model_inst (.clk, .mode(phy_mode), .sym(10'h0FA), .rx_serial, .rx_phase);

  scc_top #(.LOCK_REF(8), .EQ_INTERVAL(16)) scc_top_inst (
    .clk, .nrst, .pll_power_on, .pll_multiplier, .serdes_reference_clock, .pll_locked,
    .pll_mult_x2, .pll_mult_bad, .tx_rate, .rx_rate, .tx_rate_scale_factor_x2,
    .rx_rate_scale_factor_x2, .transmitter_on, .tx_sym_data, .tx_sym_valid, .tx_sym_ready,
    .tx_serial, .serializer_byte_clock, .receiver_on, .rx_serial, .rx_phase,
    .signal_loss_monitor, .signal_loss_detect, .clock_recovery_mode, .cdr_phase, .cdr_freq,
    .cdr_frozen, .align_mode, .align_jog, .rx_sym_data, .rx_sym_valid, .rx_comma_seen,
    .adaptive_gain_setting, .eq_boost_vote, .eq_cut_vote, .eq_gain, .eq_zero
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A wait that ran out of cycles ends the run
  task automatic bound(input string what, input int lim);
    check(what, 16'(n < lim), 16'h1);
    if (n >= lim)
      give_verdict();
  endtask

  initial
  begin
    {nrst, pll_power_on, transmitter_on, tx_sym_valid, receiver_on} = 5'h00;
    {signal_loss_monitor, signal_loss_detect, clock_recovery_mode, align_jog} = 4'h0;
    {eq_boost_vote, eq_cut_vote} = 2'h0;
    {tx_rate, rx_rate, phy_mode} = 6'h00;
    align_mode = 2'h1;
    pll_multiplier = 4'h3;
    adaptive_gain_setting = 4'h0;
    tx_sym_data = 10'h000;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    check("lock", pll_locked, 1'b0);
    check("gain", eq_gain, 4'hF);
    check("zero", eq_zero, 3'h4);
    $display("end reset");
    for (int i = 0; i < 11; i++)
    begin
      pll_multiplier = 4'(i);
      @(negedge clk);
      check("mult", pll_mult_x2, mult_x2[i]);
      check("bad", pll_mult_bad, 16'(i > 9));
    end
    for (int i = 0; i < 4; i++)
    begin
      tx_rate = 2'(i);
      rx_rate = 2'(3 - i);
      @(negedge clk);
      check("tx_scale", tx_rate_scale_factor_x2, scale_x2[i]);
      check("rx_scale", rx_rate_scale_factor_x2, scale_x2[3 - i]);
    end
    {tx_rate, rx_rate} = 4'h0;
    $display("end decode");
    pll_power_on = 1'b1;
    repeat (200) @(negedge clk);
    check("lock_bad", pll_locked, 1'b0);
    pll_power_on = 1'b0;
    pll_multiplier = 4'h3;
    @(negedge clk);
    pll_power_on = 1'b1;
    repeat (120) @(negedge clk);
    check("lock_early", pll_locked, 1'b0);
    for (n = 0; n < 40 && pll_locked !== 1'b1; n++) @(negedge clk);
    bound("lock", 40);
    $display("end pll");
    transmitter_on = 1'b1;
    repeat (12) @(negedge clk);
    tx_sym_data = 10'h2D9;
    tx_sym_valid = 1'b1;
    @(negedge clk);
    tx_sym_valid = 1'b0;
    for (int i = 9; i >= 0; i--)
    begin
      @(negedge clk);
      check("tx_bit", tx_serial, tx_sym_data[i]);
    end
    transmitter_on = 1'b0;
    repeat (2) @(negedge clk);
    tx_sym_valid = 1'b1;
    n = 0;
    for (int i = 0; i < 12; i++)
    begin
      tx_sym_data = 10'h100 + 10'(i);
      n += int'(tx_sym_ready === 1'b1);
      @(negedge clk);
    end
    tx_sym_valid = 1'b0;
    check("fill", 16'(n), 16'h8);
    check("ready", tx_sym_ready, 1'b0);
    check("tx_off", tx_serial, 1'b0);
    n = 0;
    for (int i = 0; i < 20; i++)
    begin
      p0[0] = serializer_byte_clock;
      @(negedge clk);
      n += int'(p0[0] !== serializer_byte_clock);
    end
    check("byte_clock", 16'(n), 16'h4);
    transmitter_on = 1'b1;
    for (n = 0; n < 15 && tx_sym_ready !== 1'b1; n++) @(negedge clk);
    bound("drain", 15);
    repeat (90) @(negedge clk);
    $display("end transmit");
    phy_mode = 2'h2;
    repeat (30) @(negedge clk);
    check("comma_off", rx_comma_seen, 1'b0);
    receiver_on = 1'b1;
    for (n = 0; n < 40 && rx_comma_seen !== 1'b1; n++) @(negedge clk);
    bound("comma", 40);
    for (n = 0; n < 12 && rx_sym_valid !== 1'b1; n++) @(negedge clk);
    bound("sym_valid", 12);
    check("sym", rx_sym_data, 10'h0FA);
    align_mode = 2'h0;
    align_jog = 1'b1;
    n = 0;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge clk);
      n += int'(rx_sym_valid === 1'b1);
    end
    check("jog_hold", 16'(n), 16'h0);
    align_mode = 2'h1;
    for (n = 0; n < 16 && rx_sym_valid !== 1'b1; n++) @(negedge clk);
    bound("jog_ignored", 16);
    check("sym_realign", rx_sym_data, 10'h0FA);
    align_jog = 1'b0;
    phy_mode = 2'h1;
    repeat (20) @(negedge clk);
    p0 = cdr_phase;
    repeat (16) @(negedge clk);
    check("phase_early", cdr_phase, 7'(p0 - 7'h2));
    clock_recovery_mode = 1'b1;
    p0 = cdr_phase;
    repeat (16) @(negedge clk);
    check("freq_second", 16'(cdr_freq), 16'hFFFE);
    check("phase_second", cdr_phase, 7'(p0 - 7'h5));
    clock_recovery_mode = 1'b0;
    {signal_loss_monitor, signal_loss_detect} = 2'h3;
    repeat (2) @(negedge clk);
    check("frozen", cdr_frozen, 1'b1);
    p0 = cdr_phase;
    repeat (16) @(negedge clk);
    check("phase_frozen", cdr_phase, p0);
    signal_loss_detect = 1'b0;
    phy_mode = 2'h0;
    repeat (12) @(negedge clk);
    p0 = cdr_phase;
    repeat (16) @(negedge clk);
    check("phase_quiet", cdr_phase, p0);
    $display("end receive");
    adaptive_gain_setting = 4'h1;
    eq_boost_vote = 1'b1;
    for (n = 0; n < 40 && eq_zero === 3'h4; n++) @(negedge clk);
    bound("zero_move", 40);
    check("zero_up", eq_zero, 3'h5);
    check("gain_max", eq_gain, 4'hF);
    eq_boost_vote = 1'b0;
    eq_cut_vote = 1'b1;
    for (n = 0; n < 40 && eq_gain === 4'hF; n++) @(negedge clk);
    bound("gain_move", 40);
    check("gain_down", eq_gain, 4'hE);
    adaptive_gain_setting = 4'hA;
    repeat (4) @(negedge clk);
    check("zero_fixed", eq_zero, 3'h2);
    adaptive_gain_setting = 4'h0;
    repeat (4) @(negedge clk);
    check("gain_flat", eq_gain, 4'hF);
    $display("end equalizer");
    nrst = 1'b0;
    align_mode = 2'h0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    check("lock_rst", pll_locked, 1'b0);
    check("ready_rst", tx_sym_ready, 1'b1);
    $display("end second reset");
    give_verdict();
  end
endmodule
